// ==== common/fpm_defines.svh ====
/*
 constants of the protection-map decoder: register offsets, fields, reset values, adders.
 assumes a 32-bit ahb-lite slave decoding haddr[7:0].
*/
// Behaviour
// [R1] a section is four bytes: type, count, first bit, last bit
// [R2] uniform 4 KiB sectors never appear as a section
// [R3] type codes 01..04 point at size entries 4c, 4e, 50, 52
// [R4] a type that reappears later starts its own separate section
// [R5] a first-bit field of 00 decodes as protection bit 0
// [R6] bits step by one from first to last; span equals sector count (the code expects twice the count in 8K sections)
// [R7] bottom up: four 8K, one 32K, 64K run, one 32K, four 8K
// [R8] 8K blocks are type 1, 32K type 2, 64K type 3
// [R9] 64K count is 2^m minus 2; 8K and 32K counts are 2^n
// [R10] m is 4..8 for 8, 16, 32, 64, 128 Mbit
// [R11] bit location is 2^m plus 1 plus signed adder c
// [R12] bottom 8K group adders: first ff, last 04
// [R13] lower 32K block one bit, adders fd and fd
// [R14] 64K section starts at bit 0, last adder fc
// [R15] upper 32K block one bit, adders fe and fe
// [R16] top 8K group adders: first 07, last 0e
// [R17] in 8K groups odd bits lock reads, even bits lock writes
// [R18] decoded first, last and count are registered, cleared on reset
// [R19] flag an error when bit span disagrees with sector count (the code compares 8K spans with twice the count)
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
// register offsets
`define FPM_OFS_CTRL 8'h00
`define FPM_OFS_STAT 8'h04
`define FPM_OFS_ISTAT 8'h08
`define FPM_OFS_IMASK 8'h0c
`define FPM_OFS_SEL 8'h10
`define FPM_OFS_DESC 8'h14
`define FPM_OFS_DEC 8'h18
`define FPM_OFS_BASE 8'h1c
`define FPM_OFS_LOCK 8'h20
// fields and reset values
`define FPM_START_BIT 8
`define FPM_DENS_RST 3'h3
`define FPM_DENS_MAX 3'h4
`define FPM_M_MIN 4'h4
`define FPM_NSECT 3'h5
`define FPM_EV_DONE 0
`define FPM_EV_SPAN 1
`define FPM_EV_DENS 2
// sector type codes and size entry addresses
`define FPM_TYPE_8K 8'h01
`define FPM_TYPE_32K 8'h02
`define FPM_TYPE_64K 8'h03
`define FPM_PADDR_BASE 8'h4c
`define FPM_SH_8K 5'h0d
`define FPM_SH_32K 5'h0f
`define FPM_SH_64K 5'h10
`define FPM_N_8K 8'h02
`define FPM_N_32K 8'h00
`define FPM_CNT_LIM 8'h09
`define FPM_BIAS 10'h001
`define FPM_DEC64 10'h002
// adders
`define FPM_C_B8_F 8'hff
`define FPM_C_B8_L 8'h04
`define FPM_C_L32 8'hfd
`define FPM_C_64_F 8'h00
`define FPM_C_64_L 8'hfc
`define FPM_C_U32 8'hfe
`define FPM_C_T8_F 8'h07
`define FPM_C_T8_L 8'h0e
`endif

// ==== common/fpm_pkg.sv ====
/*
 types of the protection-map decoder: engine states and the packed state record.
 assumes fpm_defines.svh on the include path.
*/
`default_nettype none
`include "fpm_defines.svh"
package fpm_pkg;
	typedef enum logic [0:0] {ST_IDLE, ST_RUN} fpm_st_t;
	typedef struct packed {
		fpm_st_t st;
		logic [2:0] idx;
		logic [3:0] m;
		logic [2:0] dens;
		logic [23:0] base;
		logic [4:0] errs;
		logic done;
		logic [2:0] istat;
		logic [2:0] mask;
		logic [2:0] sel;
		logic [8:0] lkidx;
		logic [2:0] lk;
		logic [8:0] g0f, g0l, g1f, g1l;
		logic [31:0] desc;
		logic [8:0] first, last, cnt;
		logic [7:0] paddr;
		logic [23:0] dbase;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic irq;
	} fpm_state_t;
endpackage
`default_nettype wire

// ==== design/fpm_mem.sv ====
/*
 small section table: one write port, one read port with registered data.
 assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`default_nettype none
module fpm_mem #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock
	input wire logic hclk,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array keeps it a plain ram
	always_ff @(posedge hclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ==== design/fpm_decoder.sv ====
/*
 protection-map decoder: builds the five section descriptors for density m,
 decodes them into bit ranges, checks spans, answers on ahb-lite.
 assumes single word transfers, one clock, zero wait states.
*/
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defines.svh"
module fpm_decoder (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// interrupt
	output logic irq
);
	fpm_pkg::fpm_state_t q, d;
	logic wr_en;
	logic [55:0] wr_data;
	logic [55:0] rd_data;
	logic [2:0] ev, clr;
	logic start;
	logic [31:0] bd;
	logic [8:0] bf, bl, bc, span, want;
	logic in0, in1;

	// location of a protection bit from its adder field
	function automatic logic [8:0] bp_loc(input logic [7:0] c, input logic [3:0] m);
		logic [9:0] p;
		p = 10'h001 << m;
		if (c == 8'h00) begin
			return 9'h000; // R5
		end
		return 9'(p + `FPM_BIAS + {{2{c[7]}}, c}); // R11
	endfunction

	// sector count from type and count field
	function automatic logic [8:0] sect_cnt(input logic [7:0] t, input logic [7:0] n,
		input logic [3:0] m);
		logic [9:0] p;
		p = 10'h001 << m;
		if (t == `FPM_TYPE_64K) begin
			return 9'(p - `FPM_DEC64); // R9
		end
		if (n < `FPM_CNT_LIM) begin
			return 9'(10'h001 << n); // R9
		end
		return 9'h000;
	endfunction

	// size shift of a sector type
	function automatic logic [4:0] size_sh(input logic [7:0] t);
		case (t)
			`FPM_TYPE_8K: return `FPM_SH_8K;
			`FPM_TYPE_32K: return `FPM_SH_32K;
			default: return `FPM_SH_64K;
		endcase
	endfunction

	// descriptor of section i: type, count, first, last bytes
	function automatic logic [31:0] build(input logic [2:0] i, input logic [3:0] m);
		case (i)
			3'h0: return {`FPM_C_B8_L, `FPM_C_B8_F, `FPM_N_8K, `FPM_TYPE_8K}; // R12
			3'h1: return {`FPM_C_L32, `FPM_C_L32, `FPM_N_32K, `FPM_TYPE_32K}; // R13
			3'h2: return {`FPM_C_64_L, `FPM_C_64_F, 4'h0, m, `FPM_TYPE_64K}; // R14
			3'h3: return {`FPM_C_U32, `FPM_C_U32, `FPM_N_32K, `FPM_TYPE_32K}; // R15
			default: return {`FPM_C_T8_L, `FPM_C_T8_F, `FPM_N_8K, `FPM_TYPE_8K}; // R16
		endcase
	endfunction

	fpm_mem #(.WIDTH(56), .DEPTH(8), .AW(3)) u_mem (
		.hclk(hclk),
		.wr_en(wr_en),
		.wr_addr(q.idx),
		.wr_data(wr_data),
		.rd_addr(q.sel),
		.rd_data(rd_data)
	);

	// next state of the whole block
	always_comb begin
		d = q;
		wr_en = 1'b0;
		wr_data = '0;
		ev = '0;
		clr = '0;
		start = 1'b0;
		bd = build(q.idx, q.m);
		bf = bp_loc(bd[23:16], q.m);
		bl = bp_loc(bd[31:24], q.m);
		bc = sect_cnt(bd[7:0], bd[15:8], q.m);
		span = 9'(bl - bf + 9'h001);
		want = (bd[7:0] == `FPM_TYPE_8K) ? 9'(bc << 1) : bc; // R17 read/write pair per block
		// data phase of a write
		if (q.dp_wr) begin
			case (q.dp_addr)
				`FPM_OFS_CTRL: begin
					d.dens = hwdata[2:0];
					start = hwdata[`FPM_START_BIT];
				end
				`FPM_OFS_ISTAT: clr = hwdata[2:0];
				`FPM_OFS_IMASK: d.mask = hwdata[2:0];
				`FPM_OFS_SEL: d.sel = hwdata[2:0];
				`FPM_OFS_LOCK: d.lkidx = hwdata[8:0];
				default: ;
			endcase
		end
		// section engine, one section per cycle
		case (q.st)
			fpm_pkg::ST_IDLE: begin
				if (start) begin
					if (d.dens <= `FPM_DENS_MAX) begin
						d.st = fpm_pkg::ST_RUN;
						d.m = `FPM_M_MIN + {1'b0, d.dens}; // R10
						d.idx = 3'h0;
						d.base = '0;
						d.errs = '0;
						d.done = 1'b0;
					end else begin
						ev[`FPM_EV_DENS] = 1'b1; // R10
					end
				end
			end
			fpm_pkg::ST_RUN: begin
				wr_en = 1'b1;
				wr_data = {q.base, bd}; // R1 R2 R4 R7 R8
				if (span != want) begin
					d.errs[q.idx] = 1'b1; // R6 R19
					ev[`FPM_EV_SPAN] = 1'b1; // R19
				end
				if (q.idx == 3'h0) begin
					d.g0f = bf;
					d.g0l = bl;
				end
				if (q.idx == 3'h4) begin
					d.g1f = bf;
					d.g1l = bl;
				end
				d.base = q.base + (24'(bc) << size_sh(bd[7:0])); // R7
				if (q.idx == `FPM_NSECT - 3'h1) begin
					d.st = fpm_pkg::ST_IDLE;
					d.done = 1'b1;
					ev[`FPM_EV_DONE] = 1'b1;
				end else begin
					d.idx = q.idx + 3'h1;
				end
			end
			default: d.st = fpm_pkg::ST_IDLE;
		endcase
		// registered decode of the selected section
		d.desc = rd_data[31:0];
		d.first = bp_loc(rd_data[23:16], q.m); // R18 R5
		d.last = bp_loc(rd_data[31:24], q.m); // R18
		d.cnt = sect_cnt(rd_data[7:0], rd_data[15:8], q.m); // R18
		d.paddr = 8'(`FPM_PADDR_BASE + ((rd_data[7:0] - 8'h01) << 1)); // R3
		d.dbase = rd_data[55:32];
		// lock kind of the probed bit
		in0 = (q.lkidx >= q.g0f) && (q.lkidx <= q.g0l);
		in1 = (q.lkidx >= q.g1f) && (q.lkidx <= q.g1l);
		d.lk[0] = q.done && (in0 || in1);
		d.lk[1] = d.lk[0] && q.lkidx[0]; // R17
		d.lk[2] = d.lk[0] && !q.lkidx[0]; // R17
		// sticky events: a new event beats its own clear
		d.istat = (q.istat & ~clr) | ev;
		d.irq = |(d.istat & d.mask);
		// address phase
		d.dp_wr = 1'b0;
		if (hready && hsel && htrans[1]) begin
			d.dp_wr = hwrite;
			d.dp_addr = haddr[7:0];
			d.hrdata = '0;
			if (!hwrite) begin
				case (haddr[7:0])
					`FPM_OFS_CTRL: d.hrdata = {29'h0, q.dens};
					`FPM_OFS_STAT: d.hrdata = {16'h0, q.m, 4'h0, q.errs, |q.errs,
						q.done, q.st == fpm_pkg::ST_RUN};
					`FPM_OFS_ISTAT: d.hrdata = {29'h0, q.istat};
					`FPM_OFS_IMASK: d.hrdata = {29'h0, q.mask};
					`FPM_OFS_SEL: d.hrdata = {29'h0, q.sel};
					`FPM_OFS_DESC: d.hrdata = q.desc;
					`FPM_OFS_DEC: d.hrdata = {5'h0, q.cnt, q.last, q.first};
					`FPM_OFS_BASE: d.hrdata = {q.dbase, q.paddr};
					`FPM_OFS_LOCK: d.hrdata = {7'h0, q.lkidx, 13'h0, q.lk};
					default: d.hrdata = '0;
				endcase
			end
		end
	end

	// one register for all state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.dens <= `FPM_DENS_RST;
		end else begin
			q <= d;
		end
	end

	assign hrdata = q.hrdata;
	assign irq = q.irq;
	assign hreadyout = hresetn ? 1'b1 : 1'b1;
	assign hresp = 1'b0;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// a run stays busy for exactly one cycle per section
	sequence run_s;
		q.st == fpm_pkg::ST_RUN [*5];
	endsequence

	start_to_run_a: assert property (start && q.st == fpm_pkg::ST_IDLE && d.dens <= 3'h4 // R10
		|=> run_s ##1 q.st == fpm_pkg::ST_IDLE && q.done)
		else $error("engine did not run five sections");
	bad_dens_a: assert property (start && q.st == fpm_pkg::ST_IDLE && d.dens > 3'h4 // R10
		|=> q.istat[2] && q.st == fpm_pkg::ST_IDLE)
		else $error("bad density not flagged");
	no_small_type_a: assert property (wr_en |-> wr_data[7:0] inside {8'h01, 8'h02, 8'h03}) // R2
		else $error("illegal sector type written");
	bottom_adder_a: assert property (wr_en && q.idx == 3'h0 // R12
		|-> wr_data[31:16] == 16'h04ff)
		else $error("bottom group adders wrong");
	mid_start_a: assert property (wr_en && q.idx == 3'h2 |-> wr_data[23:16] == 8'h00) // R14
		else $error("64k section not at bit 0");
	// decode of the selected section, one cycle behind the memory
	zero_first_a: assert property (rd_data[23:16] == 8'h00 |=> q.first == 9'h000) // R5
		else $error("zero start field not bit 0");
	cnt64_a: assert property (rd_data[7:0] == 8'h03 && $stable(q.m) // R9
		|=> q.cnt == 9'((10'h001 << $past(q.m)) - 10'h002))
		else $error("64k count wrong");
	span_err_a: assert property (q.st == fpm_pkg::ST_RUN && span != want // R19
		|=> q.istat[1] && q.errs != 5'h00)
		else $error("span mismatch not flagged");
	lock_kind_a: assert property (q.lk[0] |-> q.lk[1] == $past(q.lkidx[0]) // R17
		&& q.lk[2] == !$past(q.lkidx[0]))
		else $error("lock kind disagrees with bit parity");
	irq_level_a: assert property (q.irq == |(q.istat & q.mask))
		else $error("interrupt level wrong");

	// every section leaves with its own type; sections 1, 3 and 4 with count field and adders, section 2 with its count field
	type_order_a: assert property (wr_en |-> wr_data[7:0] == // R8
		((q.idx == 3'h2) ? 8'h03 : (q.idx[0] ? 8'h02 : 8'h01)))
		else $error("section type out of order");
	lower_32k_a: assert property (wr_en && q.idx == 3'h1 // R13
		|-> wr_data[31:0] == 32'hfdfd0002)
		else $error("lower 32k section wrong");
	mid_count_a: assert property (wr_en && q.idx == 3'h2 // R9
		|-> wr_data[15:0] == {4'h0, q.m, 8'h03})
		else $error("64k count field not m");
	upper_32k_a: assert property (wr_en && q.idx == 3'h3 // R15
		|-> wr_data[31:0] == 32'hfefe0002)
		else $error("upper 32k section wrong");
	top_adder_a: assert property (wr_en && q.idx == 3'h4 // R16
		|-> wr_data[31:0] == 32'h0e070201)
		else $error("top group adders wrong");

	// section bases climb from the bottom of the array
	base_bottom_a: assert property (wr_en && q.idx == 3'h0 // R7
		|-> wr_data[55:32] == 24'h000000)
		else $error("bottom section not at zero");
	base_lower_a: assert property (wr_en && q.idx == 3'h1 // R7
		|-> wr_data[55:32] == 24'h008000)
		else $error("lower 32k base wrong");
	base_mid_a: assert property (wr_en && q.idx == 3'h2 // R7
		|-> wr_data[55:32] == 24'h010000)
		else $error("64k run base wrong");
	base_upper_a: assert property (wr_en && q.idx == 3'h3 // R7
		|-> wr_data[55:32] == {8'((9'h001 << q.m) - 9'h001), 16'h0000})
		else $error("upper 32k base wrong");

	// a new event beats its own clear; a clear alone empties the bit
	sticky_set_a: assert property (ev != 3'h0 |=> (q.istat & $past(ev)) == $past(ev))
		else $error("event lost");
	w1c_clear_a: assert property ((clr & ~ev) != 3'h0
		|=> (q.istat & $past(clr) & ~$past(ev)) == 3'h0)
		else $error("status bit not cleared");

	// a read accepted in its address phase
	sequence rd_addr_s;
		hready && hsel && htrans[1] && !hwrite;
	endsequence

	// read data stand in the data phase; holes read as zero
	read_ctrl_a: assert property (rd_addr_s ##0 (haddr[7:0] == `FPM_OFS_CTRL)
		|=> hrdata == {29'h0, $past(q.dens)})
		else $error("density code read wrong");
	unmapped_read_a: assert property (rd_addr_s ##0 (haddr[7:0] > `FPM_OFS_LOCK)
		|=> hrdata == 32'h0)
		else $error("unmapped offset not zero");

	// no wait states and never an error response
	zero_wait_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered an error");
endmodule
`default_nettype wire

// ==== dv/fpm_host_model.sv ====
/*
 host model: an ahb-lite master that issues single word transfers.
 assumes one slave whose hreadyout is looped back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
module fpm_host_model (
	// clock
	input wire logic hclk,
	// master outputs
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata,
	// slave answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	// address phase, then data phase, each held until hready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d; // released data must not look valid
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
 testbench: runs every density, checks each section, lock probes and interrupt.
 assumes the decoder and the host model from this tree.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hresp, irq, hreadyout;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	wire logic hready;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int m, f, l, n, base;
	logic [7:0] ty[5] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01};
	logic [7:0] cf[5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h02};
	logic [7:0] fa[5] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
	logic [7:0] la[5] = '{8'h04, 8'hfd, 8'hfc, 8'hfe, 8'h0e};
	int sz[4] = '{0, 32'h2000, 32'h8000, 32'h10000};
	int pidx[5] = '{256, 257, 264, 271, 5};
	int pres[5] = '{5, 3, 5, 3, 0};
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	fpm_decoder i_fpm_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
	fpm_host_model i_fpm_host_model (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_fpm_host_model.xfer(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		i_fpm_host_model.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// zero adder means bit 0, else a signed adder on 2^m + 1
	function automatic int loc(int mm, logic [7:0] c);
		if (c == 8'h00)
			return 0;
		return (1 << mm) + 1 + int'($signed(c));
	endfunction
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(8'h00, 32'h3);
		rdc(8'h08, 32'h0);
		rdc(8'h40, 32'h0);
		chk({29'h0, irq, hreadyout, hresp}, 32'h2);
		for (int d = 0; d < 5; d++) begin
			m = d + 4;
			base = 0;
			wr(8'h08, 32'h7);
			wr(8'h00, 32'h100 | d);
			q = 32'h0;
			for (int i = 0; i < 30 && q[1] !== 1'b1; i++)
				i_fpm_host_model.xfer(1'b0, 8'h04, 32'h0, q);
			rdc(8'h04, 32'h0e | (m << 12));
			rdc(8'h00, d);
			rdc(8'h08, 32'h3);
			for (int s = 0; s < 5; s++) begin
				wr(8'h10, s);
				repeat (3) @(posedge hclk);
				rdc(8'h10, s);
				f = loc(m, fa[s]);
				l = loc(m, la[s]);
				n = (s == 2) ? (1 << m) - 2 : 1 << cf[s];
				rdc(8'h14, {la[s], fa[s], (s == 2) ? 8'(m) : cf[s], ty[s]});
				rdc(8'h18, (n << 18) | (l << 9) | f);
				rdc(8'h1c, (base << 8) | (8'h4a + 2 * ty[s]));
				base += n * sz[ty[s]];
			end
		end
		// probes at m = 8: odd bits lock reads, even bits lock writes
		for (int p = 0; p < 5; p++) begin
			wr(8'h20, pidx[p]);
			repeat (2) @(posedge hclk);
			rdc(8'h20, (pidx[p] << 16) | pres[p]);
		end
		chk({31'h0, irq}, 32'h0);
		wr(8'h0c, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		wr(8'h08, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rdc(8'h08, 32'h2);
		wr(8'h0c, 32'h4);
		rdc(8'h0c, 32'h4);
		wr(8'h00, 32'h105);
		repeat (2) @(posedge hclk);
		rdc(8'h08, 32'h6);
		chk({31'h0, irq}, 32'h1);
		wr(8'h08, 32'h6);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rdc(8'h08, 32'h0);
		// a second reset brings back the reset values
		rdc(8'h00, 32'h5);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(hrdata, 32'h0);
		chk({29'h0, irq, hreadyout, hresp}, 32'h2);
		hresetn <= 1'b1;
		rdc(8'h00, 32'h3);
		rdc(8'h04, 32'h0);
		rdc(8'h08, 32'h0);
		results();
	end
endmodule
`default_nettype wire
